// file: design/pgc_pkg.sv
package pgc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_CONTROL = 10'h071;
  localparam logic [9:0] IDX_STATUS = 10'h072;
  localparam logic [9:0] IDX_FLAGS = 10'h073;
  localparam logic [7:0] RST_REG = 8'h00;
  // Control register fields
  localparam int CTL_RX_FLIP = 3;
  localparam int CTL_TX_FLIP = 2;
  localparam int CTL_PAT_LO = 0;
  // Status and error control fields
  localparam int SEC_MIS_IE = 3;
  localparam int SEC_INJECT = 2;
  localparam int SEC_LOCK = 1;
  localparam int SEC_LOCK_IE = 0;
  // Event flag fields; enables sit at the same positions
  localparam int FLG_MIS = 3;
  localparam int FLG_LOCK_CHG = 0;
  // Detector thresholds
  localparam int LOCK_BITS = 48;
  localparam int ERR_LIMIT = 10;
  // Shift register shared by all three sequences
  localparam int SR_W = 20;
  localparam logic [19:0] SEED = 20'hfffff;
  localparam logic [19:0] CLEAR = 20'h00000;
  // Feedback taps, x^n + x^k + 1
  localparam int T15_A = 14;
  localparam int T15_B = 13;
  localparam int T20_A = 19;
  localparam int T20_B = 16;
  localparam int T11_A = 10;
  localparam int T11_B = 8;
  typedef enum logic [1:0] {
    PAT_15 = 2'b00,
    PAT_20 = 2'b01,
    PAT_11 = 2'b10,
    PAT_RSVD = 2'b11
  } pgc_pattern_t;
  typedef enum logic {
    ST_HUNT = 1'b0,
    ST_LOCKED = 1'b1
  } pgc_lock_t;
endpackage

// file: design/pgc_prbs_gen_check.sv
// How it works
// - Two-bit select picks 2^15-1, 2^20-1 or 2^11-1; code 11 reserved.
// - Transmit flip set complements every generated bit.
// - Receive flip set complements received data before the detector.
// - Writing inject corrupts exactly one generated bit, then self-clears.
// - Ten or more errors in a 48-bit window drop lock.
// - 48 consecutive error-free bits declare lock.
// - While locked each mismatch sets the mismatch flag; write 1 clears.
// - Every lock state change sets the lock-change flag; write 1 clears.
// - Mismatch enable lets flag bit 3 drive the interrupt.
// - Lock-change enable lets flag bit 0 drive the interrupt.
// - Control: receive flip b3, transmit flip b2, select b1:0, reset 0.
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module pgc_prbs_gen_check #(
  parameter int LOCK_BITS = pgc_pkg::LOCK_BITS,
  parameter int ERR_LIMIT = pgc_pkg::ERR_LIMIT
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic tx_bit_req,
  output logic tx_data,
  input wire logic rx_bit_valid,
  input wire logic rx_data,
  output logic irq
);
  localparam int CW = $clog2(LOCK_BITS + 1);
  localparam int EW = $clog2(ERR_LIMIT + 1);
  localparam logic [CW-1:0] LAST = CW'(LOCK_BITS - 1);
  localparam logic [EW-1:0] ELIM = EW'(ERR_LIMIT);

  // Thresholds the counters cannot serve are refused
  if (LOCK_BITS < 2 || ERR_LIMIT < 1 || ERR_LIMIT > LOCK_BITS)
  begin : g_bad
    $error("Unsupported lock or error threshold");
  end

  logic [7:0] control;
  logic tx_pattern_flip;
  logic rx_data_flip;
  pgc_pkg::pgc_pattern_t pattern_select;
  pgc_pkg::pgc_pattern_t pat_prev;
  logic mismatch_irq_enable;
  logic lock_change_irq_enable;
  logic single_error_inject;
  logic mismatch_flag;
  logic lock_change_flag;
  logic lock_state;
  logic lock_prev;
  logic restart;
  logic pat_ok;
  logic [pgc_pkg::SR_W-1:0] gen;
  logic [pgc_pkg::SR_W-1:0] det;
  logic gen_fb;
  logic det_fb;
  logic rx_in;
  logic miss;
  logic tx_step;
  logic rx_step;
  pgc_pkg::pgc_lock_t state;
  logic [CW-1:0] run_cnt;
  logic [CW-1:0] win_cnt;
  logic [EW-1:0] err_cnt;
  logic [EW-1:0] next_err;
  logic dp_wr;
  logic [9:0] dp_idx;
  logic wr_ctl;
  logic wr_sec;
  logic wr_flg;
  logic ap_take;
  logic [7:0] rd_val;

  // Feedback of the selected sequence
  function automatic logic feedback(
    input logic [pgc_pkg::SR_W-1:0] s,
    input pgc_pkg::pgc_pattern_t p
  );
    case (p)
      pgc_pkg::PAT_15: feedback = s[pgc_pkg::T15_A] ^ s[pgc_pkg::T15_B];
      pgc_pkg::PAT_20: feedback = s[pgc_pkg::T20_A] ^ s[pgc_pkg::T20_B];
      pgc_pkg::PAT_11: feedback = s[pgc_pkg::T11_A] ^ s[pgc_pkg::T11_B];
      default: feedback = 1'b0;
    endcase
  endfunction

  // Control fields
  assign rx_data_flip = control[pgc_pkg::CTL_RX_FLIP];
  assign tx_pattern_flip = control[pgc_pkg::CTL_TX_FLIP];
  assign pattern_select = pgc_pkg::pgc_pattern_t'(
    control[pgc_pkg::CTL_PAT_LO +: 2]);
  assign pat_ok = (pattern_select != pgc_pkg::PAT_RSVD);
  assign restart = (pattern_select != pat_prev);

  // Zero-wait slave; every answer is OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign ap_take = hsel && hready && htrans[1];
  assign wr_ctl = dp_wr && (dp_idx == pgc_pkg::IDX_CONTROL);
  assign wr_sec = dp_wr && (dp_idx == pgc_pkg::IDX_STATUS);
  assign wr_flg = dp_wr && (dp_idx == pgc_pkg::IDX_FLAGS);

  // Address phase capture; writes land in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_wr <= 1'b0;
      dp_idx <= 10'h000;
    end
    else
    begin
      dp_wr <= ap_take && hwrite;
      dp_idx <= haddr[11:2];
    end
  end

  // Read mux; unmapped words read as zero
  always_comb
  begin
    rd_val = pgc_pkg::RST_REG;
    case (haddr[11:2])
      pgc_pkg::IDX_CONTROL: rd_val = control;
      pgc_pkg::IDX_STATUS:
      begin
        rd_val[pgc_pkg::SEC_MIS_IE] = mismatch_irq_enable;
        rd_val[pgc_pkg::SEC_INJECT] = single_error_inject;
        rd_val[pgc_pkg::SEC_LOCK] = lock_state;
        rd_val[pgc_pkg::SEC_LOCK_IE] = lock_change_irq_enable;
      end
      pgc_pkg::IDX_FLAGS:
      begin
        rd_val[pgc_pkg::FLG_MIS] = mismatch_flag;
        rd_val[pgc_pkg::FLG_LOCK_CHG] = lock_change_flag;
      end
      default: rd_val = pgc_pkg::RST_REG;
    endcase
  end

  // Read data is sampled in the address phase so it comes from a flop
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (ap_take && !hwrite)
      hrdata <= {24'h000000, rd_val};
  end

  // Control register; only the low nibble is implemented
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      control <= pgc_pkg::RST_REG;
      pat_prev <= pgc_pkg::PAT_15;
    end
    else
    begin
      pat_prev <= pattern_select;
      if (wr_ctl)
        control <= {4'h0, hwdata[3:0]};
    end
  end

  // Enables and the self-clearing inject request
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mismatch_irq_enable <= 1'b0;
      lock_change_irq_enable <= 1'b0;
      single_error_inject <= 1'b0;
    end
    else if (wr_sec)
    begin
      mismatch_irq_enable <= hwdata[pgc_pkg::SEC_MIS_IE];
      lock_change_irq_enable <= hwdata[pgc_pkg::SEC_LOCK_IE];
      // A fresh request beats the hardware clear
      single_error_inject <= hwdata[pgc_pkg::SEC_INJECT];
    end
    else if (tx_step)
      single_error_inject <= 1'b0;
  end

  // Generator: one bit per transmit request
  assign gen_fb = feedback(gen, pattern_select);
  assign tx_step = tx_bit_req && pat_ok && !restart;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gen <= pgc_pkg::SEED;
      tx_data <= 1'b0;
    end
    else if (restart)
      gen <= pgc_pkg::SEED;
    else if (tx_step)
    begin
      gen <= {gen[pgc_pkg::SR_W-2:0], gen_fb};
      tx_data <= gen_fb ^ tx_pattern_flip ^ single_error_inject;
    end
  end

  // Self-synchronising detector fed by the received bits themselves
  assign rx_in = rx_data ^ rx_data_flip;
  assign det_fb = feedback(det, pattern_select);
  assign miss = (rx_in != det_fb);
  assign rx_step = rx_bit_valid && pat_ok && !restart;
  assign lock_state = (state == pgc_pkg::ST_LOCKED);
  assign next_err = err_cnt + EW'(miss);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      det <= pgc_pkg::CLEAR;
    else if (restart)
      det <= pgc_pkg::CLEAR;
    else if (rx_step)
      det <= {det[pgc_pkg::SR_W-2:0], rx_in};
  end

  // Lock state machine; errors counted in fixed windows while locked
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= pgc_pkg::ST_HUNT;
      run_cnt <= '0;
      win_cnt <= '0;
      err_cnt <= '0;
    end
    else if (restart)
    begin
      state <= pgc_pkg::ST_HUNT;
      run_cnt <= '0;
      win_cnt <= '0;
      err_cnt <= '0;
    end
    else if (rx_step)
    begin
      case (state)
        pgc_pkg::ST_HUNT:
        begin
          if (miss)
            run_cnt <= '0;
          else if (run_cnt == LAST)
          begin
            state <= pgc_pkg::ST_LOCKED;
            win_cnt <= '0;
            err_cnt <= '0;
          end
          else
            run_cnt <= run_cnt + CW'(1);
        end
        pgc_pkg::ST_LOCKED:
        begin
          if (next_err >= ELIM)
          begin
            state <= pgc_pkg::ST_HUNT;
            run_cnt <= '0;
          end
          else if (win_cnt == LAST)
          begin
            win_cnt <= '0;
            err_cnt <= '0;
          end
          else
          begin
            win_cnt <= win_cnt + CW'(1);
            err_cnt <= next_err;
          end
        end
        default: state <= pgc_pkg::ST_HUNT;
      endcase
    end
  end

  // Sticky flags; a new event wins over a write-one clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lock_prev <= 1'b0;
      mismatch_flag <= 1'b0;
      lock_change_flag <= 1'b0;
    end
    else
    begin
      lock_prev <= lock_state;
      if (lock_state && rx_step && miss)
        mismatch_flag <= 1'b1;
      else if (wr_flg && hwdata[pgc_pkg::FLG_MIS])
        mismatch_flag <= 1'b0;
      if (lock_state != lock_prev)
        lock_change_flag <= 1'b1;
      else if (wr_flg && hwdata[pgc_pkg::FLG_LOCK_CHG])
        lock_change_flag <= 1'b0;
    end
  end

  // Level interrupt from the enabled flags
  assign irq = (mismatch_flag && mismatch_irq_enable)
    || (lock_change_flag && lock_change_irq_enable);

  a_gen_fb_sel: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_step && pattern_select == pgc_pkg::PAT_15
    |=> gen[0] == ($past(gen[14]) ^ $past(gen[13])))
    else $error("Generator feedback wrong for select 00");
  a_tx_flip_out: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_step && !single_error_inject
    |=> tx_data == (gen[0] ^ $past(tx_pattern_flip)))
    else $error("Transmit bit does not follow flip setting");
  a_rx_flip_in: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_step |=> det[0] == $past(rx_data ^ rx_data_flip))
    else $error("Receive flip not applied before detector");
  a_inject_once: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_step && single_error_inject && !wr_sec
    |=> !single_error_inject && tx_data == !(gen[0] ^ $past(tx_pattern_flip)))
    else $error("Single error inject misbehaved");
  a_unlock_errs: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_step && lock_state && miss && err_cnt == ELIM - EW'(1)
    |=> !lock_state)
    else $error("Lock kept after error limit");
  a_lock_run: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_step && !lock_state && !miss && run_cnt == LAST |=> lock_state)
    else $error("Lock not declared after error-free run");
  a_mis_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_step && lock_state && miss |=> mismatch_flag)
    else $error("Mismatch while locked not flagged");
  a_lock_chg: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(lock_state) |=> lock_change_flag)
    else $error("Lock change not flagged");
  a_irq_mask: assert property (@(posedge hclk) disable iff (!hresetn)
    (!mismatch_irq_enable || !mismatch_flag)
    && (!lock_change_irq_enable || !lock_change_flag) |-> !irq)
    else $error("Interrupt high with no enabled flag");
  a_restart_unlock: assert property (@(posedge hclk) disable iff (!hresetn)
    restart |=> !lock_state && gen == pgc_pkg::SEED)
    else $error("Select change did not restart");
endmodule
`default_nettype wire

// file: testbench/pgc_framer_model.sv
`timescale 1ns/10ps
`default_nettype none
// Framer stand-in: asks for bits on command and loops them back
module pgc_framer_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic corrupt,
  input wire logic tx_data,
  output logic tx_bit_req,
  output logic rx_bit_valid,
  output logic rx_data
);
  logic req_d;
  // Request follows run so the bench knows every bit it asked for
  assign tx_bit_req = run;
  // Return each bit a cycle later; the idle line toggles, never holds
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      req_d <= 1'h0;
      rx_bit_valid <= 1'h0;
      rx_data <= 1'h0;
    end
    else
    begin
      req_d <= tx_bit_req;
      rx_bit_valid <= req_d;
      rx_data <= req_d ? (tx_data ^ corrupt) : ~rx_data;
    end
  end
endmodule
`default_nettype wire

// file: testbench/test_pgc_prbs_gen_check.sv
`timescale 1ns/10ps
`default_nettype none
module test_pgc_prbs_gen_check;
  logic hclk, hresetn, hsel, hwrite, run, corrupt;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, tx_bit_req, tx_data, rx_bit_valid, rx_data, irq;
  logic [19:0] sm;
  int err_total, num_checks, cyc;

  pgc_prbs_gen_check pgc_prbs_gen_check_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .tx_bit_req(tx_bit_req), .tx_data(tx_data), .rx_bit_valid(rx_bit_valid),
    .rx_data(rx_data), .irq(irq));
  pgc_framer_model pgc_framer_model_inst (.hclk(hclk), .hresetn(hresetn),
    .run(run), .corrupt(corrupt), .tx_data(tx_data),
    .tx_bit_req(tx_bit_req), .rx_bit_valid(rx_bit_valid), .rx_data(rx_data));

  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One single AHB transfer; the #1 lets the data phase update land
  task automatic bus(input logic w, input logic [9:0] idx,
    input logic [31:0] d);
    @(posedge hclk);
    haddr <= {20'h00000, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
    #1;
  endtask

  // Reference feedback, kept apart from the design's own logic
  function automatic logic fbk(input logic [1:0] p, input logic [19:0] s);
    case (p)
      2'h0: return s[pgc_pkg::T15_A] ^ s[pgc_pkg::T15_B];
      2'h1: return s[pgc_pkg::T20_A] ^ s[pgc_pkg::T20_B];
      default: return s[pgc_pkg::T11_A] ^ s[pgc_pkg::T11_B];
    endcase
  endfunction

  // Ask for n bits and count looped-back bits that differ from reference
  task automatic stream(input int n, input logic [1:0] p, input logic f,
    input int exp, input string what);
    int d;
    logic b;
    d = 0;
    for (int i = 0; i < n + 3; i++)
    begin
      @(posedge hclk);
      run <= (i < n);
      #1;
      if (rx_bit_valid === 1'h1)
      begin
        b = fbk(p, sm);
        sm = {sm[18:0], b};
        d += (rx_data !== (b ^ f));
      end
    end
    chk(32'(d), 32'(exp), what);
  endtask

  // Passing through the reserved code forces a restart from the seed
  task automatic reseed(input logic [1:0] p, input logic f);
    bus(1'h1, pgc_pkg::IDX_CONTROL, {28'h0, f, f, 2'h3});
    bus(1'h1, pgc_pkg::IDX_CONTROL, {28'h0, f, f, p});
    sm = pgc_pkg::SEED;
  endtask

  task automatic t_regs;
    for (int i = 0; i < 4; i++)
    begin
      bus(1'h0, 10'h070 + i[9:0], 32'h0);
      chk(rd, 32'h0, "reset value");
    end
    bus(1'h1, pgc_pkg::IDX_CONTROL, 32'hffffffff);
    bus(1'h0, pgc_pkg::IDX_CONTROL, 32'h0);
    chk(rd, 32'hf, "control fields");
    chk({31'h0, hresp}, 32'h0, "response");
  endtask

  task automatic t_patterns;
    logic f;
    logic [1:0] pt;
    for (int p = 0; p < 3; p++)
    begin
      f = p[0];
      pt = p[1:0];
      reseed(pt, f);
      bus(1'h1, pgc_pkg::IDX_FLAGS, 32'h9);
      stream(100, pt, f, 0, "pattern bits");
      bus(1'h0, pgc_pkg::IDX_STATUS, 32'h0);
      chk(rd, 32'h2, "lock acquired");
      bus(1'h0, pgc_pkg::IDX_FLAGS, 32'h0);
      chk(rd, 32'h1, "lock change flag");
    end
    bus(1'h1, pgc_pkg::IDX_STATUS, 32'h1);
    chk({31'h0, irq}, 32'h1, "lock change irq");
    bus(1'h1, pgc_pkg::IDX_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0, "lock change masked");
    bus(1'h1, pgc_pkg::IDX_FLAGS, 32'h1);
    bus(1'h0, pgc_pkg::IDX_FLAGS, 32'h0);
    chk(rd, 32'h0, "flag cleared");
  endtask

  task automatic t_inject;
    bus(1'h1, pgc_pkg::IDX_STATUS, 32'hc);
    stream(100, 2'h2, 1'h0, 1, "one injected error");
    bus(1'h0, pgc_pkg::IDX_STATUS, 32'h0);
    chk(rd, 32'ha, "inject self clears, lock kept");
    bus(1'h0, pgc_pkg::IDX_FLAGS, 32'h0);
    chk(rd, 32'h8, "mismatch flag");
    chk({31'h0, irq}, 32'h1, "mismatch irq");
    bus(1'h1, pgc_pkg::IDX_FLAGS, 32'h8);
    chk({31'h0, irq}, 32'h0, "irq after clear");
  endtask

  // Broken loop drops lock; receive flip repairs it and lock returns
  task automatic t_lose;
    @(posedge hclk);
    corrupt <= 1'h1;
    stream(30, 2'h2, 1'h0, 30, "broken loop");
    bus(1'h0, pgc_pkg::IDX_STATUS, 32'h0);
    chk(rd, 32'h8, "lock lost");
    bus(1'h0, pgc_pkg::IDX_FLAGS, 32'h0);
    chk(rd, 32'h9, "loss flags");
    chk({31'h0, irq}, 32'h1, "mismatch irq while unlocked");
    bus(1'h1, pgc_pkg::IDX_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0, "mismatch masked");
    bus(1'h1, pgc_pkg::IDX_STATUS, 32'h8);
    bus(1'h1, pgc_pkg::IDX_FLAGS, 32'h9);
    stream(30, 2'h2, 1'h0, 30, "hunting");
    bus(1'h0, pgc_pkg::IDX_FLAGS, 32'h0);
    chk(rd, 32'h0, "no mismatch while hunting");
    bus(1'h1, pgc_pkg::IDX_CONTROL, 32'ha);
    stream(100, 2'h2, 1'h0, 100, "flipped loop");
    bus(1'h0, pgc_pkg::IDX_STATUS, 32'h0);
    chk(rd, 32'ha, "relock with receive flip");
  endtask

  initial
  begin
    hclk = 1'h0;
    forever #50 hclk = ~hclk;
  end

  // Hang guard: the whole run needs under two thousand cycles
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      print_verdict;
    end
  end

  initial
  begin
    hresetn = 1'h0;
    hsel = 1'h1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    run = 1'h0;
    corrupt = 1'h0;
    sm = pgc_pkg::SEED;
    repeat (3) @(posedge hclk);
    hresetn <= 1'h1;
    t_regs;
    t_patterns;
    t_inject;
    t_lose;
    print_verdict;
  end
endmodule
`default_nettype wire
